// File: core/usart_irq_pkg.sv
/*
 * constants of the serial unit's interrupt-enable, debug-halt and baud
 * register bank: offsets, field positions, reset values, bus widths.
 * assumes a byte-addressed plain register port with 16-bit data.
 */
package usart_irq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SRC_N = 4;
    // register byte offsets
    localparam logic [ADDR_W-1:0] DBG_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] BAUD_OFF = 8'h0a;
    localparam logic [ADDR_W-1:0] ENCLR_OFF = 8'h0c;
    localparam logic [ADDR_W-1:0] ENSET_OFF = 8'h0d;
    localparam logic [ADDR_W-1:0] FLAG_OFF = 8'h0e;
    // field positions; halt in the debug register, the rest shared by enable and flag registers
    localparam int HALT_BIT = 0;
    localparam int RECV_START_BIT = 3;
    localparam int RECV_DONE_BIT = 2;
    localparam int XMIT_DONE_BIT = 1;
    localparam int HOLD_EMPTY_BIT = 0;
    // reset values
    localparam logic HALT_RST = 1'b0;
    localparam logic [DATA_W-1:0] BAUD_RST = 16'h0000;
    localparam logic [SRC_N-1:0] EN_RST = 4'h0;
    localparam logic [SRC_N-1:0] FLAG_RST = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
    localparam logic RX_IDLE = 1'b1;
endpackage : usart_irq_pkg

// File: core/usart_irq_bank.sv
/*
 * register bank: debug-halt control, baud divisor, interrupt enable
 * set/clear pair, interrupt flags and the unit's interrupt line.
 * assumes transmit/receive status inputs come from logic on the same
 * clock; only the receive line is a pin and is synchronised here.
 */
`timescale 1ns/1ps
module usart_irq_bank (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [usart_irq_pkg::ADDR_W-1:0] addr,
    input wire logic [usart_irq_pkg::DATA_W-1:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [usart_irq_pkg::DATA_W-1:0] rdata,
    input wire logic cpu_debug_halted,
    input wire logic rx_line,
    input wire logic frame_start_detect_enable,
    input wire logic tx_shift_done,
    input wire logic tx_data_written,
    input wire logic rx_data_unread,
    input wire logic tx_holding_empty,
    output logic [usart_irq_pkg::DATA_W-1:0] baud_value,
    output logic baud_run,
    output logic irq
);
    import usart_irq_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // receive line synchroniser and start edge

    logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
    logic nxt_rx_meta, nxt_rx_sync, nxt_rx_prev;
    logic start_det;

    // idle line is high; a start bit is the fall to low
    always_comb begin
        nxt_rx_meta = rx_line;
        nxt_rx_sync = rx_meta_ff;
        nxt_rx_prev = rx_sync_ff;
    end

    assign start_det = rx_prev_ff & ~rx_sync_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_meta_ff <= RX_IDLE;
            rx_sync_ff <= RX_IDLE;
            rx_prev_ff <= RX_IDLE;
        end else if (clk_en) begin
            rx_meta_ff <= nxt_rx_meta;
            rx_sync_ff <= nxt_rx_sync;
            rx_prev_ff <= nxt_rx_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers

    logic halt_on_debug_ff, nxt_halt_on_debug;
    logic [DATA_W-1:0] baud_ff, nxt_baud;
    logic [SRC_N-1:0] en_ff, nxt_en;
    logic wr_dbg, wr_baud, wr_clr, wr_set, wr_flag;

    assign wr_dbg = wr_strobe & hit(addr, DBG_OFF);
    assign wr_baud = wr_strobe & hit(addr, BAUD_OFF);
    assign wr_clr = wr_strobe & hit(addr, ENCLR_OFF);
    assign wr_set = wr_strobe & hit(addr, ENSET_OFF);
    assign wr_flag = wr_strobe & hit(addr, FLAG_OFF);

    // one enable vector behind both addresses, so no read-modify-write
    always_comb begin
        nxt_halt_on_debug = halt_on_debug_ff;
        nxt_baud = baud_ff;
        nxt_en = en_ff;
        if (wr_dbg) begin
            nxt_halt_on_debug = wdata[HALT_BIT];
        end
        if (wr_baud) begin
            nxt_baud = wdata;
        end
        if (wr_clr) begin
            nxt_en = en_ff & ~wdata[SRC_N-1:0];
        end
        if (wr_set) begin
            nxt_en = en_ff | wdata[SRC_N-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            halt_on_debug_ff <= HALT_RST;
            baud_ff <= BAUD_RST;
            en_ff <= EN_RST;
        end else if (clk_en) begin
            halt_on_debug_ff <= nxt_halt_on_debug;
            baud_ff <= nxt_baud;
            en_ff <= nxt_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt flags

    logic [SRC_N-1:0] flag_ff, nxt_flag;

    // receive-start and transmit-done are sticky, a set in the clearing cycle wins over the clear; the other two follow their sources
    always_comb begin
        nxt_flag = flag_ff;
        nxt_flag[RECV_START_BIT] = (flag_ff[RECV_START_BIT] & ~(wr_flag & wdata[RECV_START_BIT]))
            | (start_det & frame_start_detect_enable);
        nxt_flag[XMIT_DONE_BIT] = (flag_ff[XMIT_DONE_BIT] & ~(wr_flag & wdata[XMIT_DONE_BIT]) & ~tx_data_written)
            | tx_shift_done;
        nxt_flag[RECV_DONE_BIT] = rx_data_unread;
        nxt_flag[HOLD_EMPTY_BIT] = tx_holding_empty;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            flag_ff <= FLAG_RST;
        end else if (clk_en) begin
            flag_ff <= nxt_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs and read port

    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic baud_run_ff, nxt_baud_run;
    logic irq_ff, nxt_irq;

    // read data stands only in the cycle after the strobe
    always_comb begin
        nxt_rdata = RDATA_RST;
        if (rd_strobe) begin
            if (hit(addr, DBG_OFF)) begin
                nxt_rdata[HALT_BIT] = halt_on_debug_ff;
            end else if (hit(addr, BAUD_OFF)) begin
                nxt_rdata = baud_ff;
            end else if (hit(addr, ENCLR_OFF) || hit(addr, ENSET_OFF)) begin
                nxt_rdata[SRC_N-1:0] = en_ff;
            end else if (hit(addr, FLAG_OFF)) begin
                nxt_rdata[SRC_N-1:0] = flag_ff;
            end
        end
        // generator runs unless halting on debug is asked and cpu is halted
        nxt_baud_run = ~(nxt_halt_on_debug & cpu_debug_halted);
        // computed from next values so the line matches the registers
        nxt_irq = |(nxt_flag & nxt_en);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_ff <= RDATA_RST;
            baud_run_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
            baud_run_ff <= nxt_baud_run;
            irq_ff <= nxt_irq;
        end
    end

    assign rdata = rdata_ff;
    assign baud_value = baud_ff;
    assign baud_run = baud_run_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    run_on_debug_a: assert property (
        (clk_en && !nxt_halt_on_debug) |=> baud_run)
        else $error("baud generator stopped with halt bit clear");

    halt_on_debug_a: assert property (
        (clk_en && wr_dbg && wdata[HALT_BIT] && cpu_debug_halted) |=> !baud_run)
        else $error("baud generator kept running during debug halt");

    baud_write_a: assert property (
        (clk_en && wr_baud) |=> (baud_value == $past(wdata)))
        else $error("baud value did not take the written word");

    enable_clear_a: assert property (
        (clk_en && wr_clr) |=> ((en_ff & $past(wdata[SRC_N-1:0])) == 4'h0))
        else $error("enable not cleared by clear write");

    clear_only_xmit_a: assert property (
        (clk_en && wr_clr && wdata[SRC_N-1:0] == 4'h2) |=> (en_ff == ($past(en_ff) & 4'hd)))
        else $error("transmit-done clear disturbed other enables");

    zero_write_a: assert property (
        (clk_en && (wr_clr || wr_set) && wdata[SRC_N-1:0] == 4'h0) |=> $stable(en_ff))
        else $error("zero write changed the enables");

    enable_set_a: assert property (
        (clk_en && wr_set) |=> ((en_ff & $past(wdata[SRC_N-1:0])) == $past(wdata[SRC_N-1:0])))
        else $error("enable not set by set write");

    shared_read_a: assert property (
        (clk_en && rd_strobe && (hit(addr, ENCLR_OFF) || hit(addr, ENSET_OFF)))
        |=> (rdata == {12'h000, $past(en_ff)}))
        else $error("enable register read back wrong");

    irq_level_a: assert property (
        irq == |(flag_ff & en_ff))
        else $error("interrupt line disagrees with flags and enables");

    recv_start_set_a: assert property (
        (clk_en && start_det && frame_start_detect_enable) |=> flag_ff[RECV_START_BIT])
        else $error("receive start flag not set");

    xmit_done_set_a: assert property (
        (clk_en && tx_shift_done) |=> flag_ff[XMIT_DONE_BIT])
        else $error("transmit done flag not set");

    level_flags_a: assert property (
        clk_en |=> (flag_ff[RECV_DONE_BIT] == $past(rx_data_unread)
            && flag_ff[HOLD_EMPTY_BIT] == $past(tx_holding_empty)))
        else $error("level flag does not follow its source");

    reset_zero_a: assert property (
        $past(reset) |-> (baud_value == 16'h0000 && en_ff == 4'h0 && !halt_on_debug_ff))
        else $error("registers not zero after reset");

    // divisor must not drift between writes, the generator reads it every bit
    baud_hold_a: assert property (
        !(clk_en && wr_baud) |=> $stable(baud_value))
        else $error("baud value changed without a write");

    // enables move only through the set or clear address
    enable_hold_a: assert property (
        !(clk_en && (wr_clr || wr_set)) |=> $stable(en_ff))
        else $error("enables changed without a set or clear write");

    // holding-empty enable sits at the lowest bit of both registers
    set_bit_pos_a: assert property (
        (clk_en && wr_set && wdata[SRC_N-1:0] == 4'h1) |=> (en_ff == ($past(en_ff) | 4'h1)))
        else $error("set write hit the wrong enable bit");

    // holding-empty enable taken from a set write
    hold_empty_set_a: assert property (
        (clk_en && wr_set && wdata[HOLD_EMPTY_BIT]) |=> en_ff[HOLD_EMPTY_BIT])
        else $error("holding-empty enable not set");

    // receive start enable dropped by a clear write
    start_clear_a: assert property (
        (clk_en && wr_clr && wdata[RECV_START_BIT]) |=> !en_ff[RECV_START_BIT])
        else $error("receive start enable not cleared");

    // read data is zero outside the cycle after a read strobe
    read_idle_zero_a: assert property (
        (clk_en && !rd_strobe) |=> (rdata == 16'h0000))
        else $error("read data stood outside its cycle");

    // unmapped offsets read as zero
    unmapped_read_a: assert property (
        (clk_en && rd_strobe && !(hit(addr, DBG_OFF) || hit(addr, BAUD_OFF)
            || hit(addr, ENCLR_OFF) || hit(addr, ENSET_OFF) || hit(addr, FLAG_OFF)))
        |=> (rdata == 16'h0000))
        else $error("unmapped read returned data");

    // halt bit reads back in bit 0, rest zero
    halt_read_a: assert property (
        (clk_en && rd_strobe && hit(addr, DBG_OFF)) |=> (rdata == {15'h0000, $past(halt_on_debug_ff)}))
        else $error("halt bit read back wrong");

    // generator runs whenever the cpu is not halted
    run_free_a: assert property (
        (clk_en && !cpu_debug_halted) |=> baud_run)
        else $error("baud generator stopped without a debug halt");

    // clock enable low freezes the enables, the divisor, the flags and the interrupt line
    frozen_state_a: assert property (
        !clk_en |=> ($stable(en_ff) && $stable(baud_value) && $stable(flag_ff) && $stable(irq)))
        else $error("state moved while clock enable was low");

    // set beats clear when both fall in one cycle
    start_wins_a: assert property (
        (clk_en && start_det && frame_start_detect_enable && wr_flag && wdata[RECV_START_BIT])
        |=> flag_ff[RECV_START_BIT])
        else $error("receive start lost to a same-cycle clear");

    // new transmit data drops the transmit-done flag
    xmit_done_clear_a: assert property (
        (clk_en && tx_data_written && !tx_shift_done) |=> !flag_ff[XMIT_DONE_BIT])
        else $error("transmit done flag not cleared by new data");

    // main scenarios: interrupt raise, debug stop, flag clear, start detect, divisor load
    irq_raise_c: cover property (clk_en && wr_set ##1 irq);
    debug_stop_c: cover property (halt_on_debug_ff && cpu_debug_halted ##1 !baud_run);
    flag_clear_c: cover property (flag_ff[XMIT_DONE_BIT] ##1 clk_en && wr_flag ##1 !flag_ff[XMIT_DONE_BIT]);
    recv_start_c: cover property (clk_en && start_det && frame_start_detect_enable ##1 irq);
    baud_load_c: cover property (clk_en && wr_baud ##1 baud_value != 16'h0000);

endmodule : usart_irq_bank

// File: dv/tb_usart_irq_bank.sv
/*
 * self-checking bench for the interrupt-enable, debug-halt and baud bank.
 * assumes the plain register port of the bank: strobes one cycle long,
 * read data in the cycle after the read strobe only.
 */
`timescale 1ns/1ps
module tb_usart_irq_bank;
    import usart_irq_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic cpu_debug_halted = 1'b0;
    logic rx_line = 1'b1;
    logic frame_start_detect_enable = 1'b0;
    logic tx_shift_done = 1'b0;
    logic tx_data_written = 1'b0;
    logic rx_data_unread = 1'b0;
    logic tx_holding_empty = 1'b0;
    logic [DATA_W-1:0] baud_value;
    logic baud_run;
    logic irq;
    logic [SRC_N-1:0] exp_en;
    int error_cnt = 0;
    int checked = 0;
    int n;

    // free-running 100 MHz clock
    always #5 clock = ~clock;

    usart_irq_bank u_dut (.clock(clock), .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .cpu_debug_halted(cpu_debug_halted),
        .rx_line(rx_line), .frame_start_detect_enable(frame_start_detect_enable),
        .tx_shift_done(tx_shift_done), .tx_data_written(tx_data_written), .rx_data_unread(rx_data_unread),
        .tx_holding_empty(tx_holding_empty), .baud_value(baud_value), .baud_run(baud_run), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus cycles and waiting
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one write cycle; the lowering edge keeps a gap before the next strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        #1;
    endtask : wr

    // read data is only valid in the cycle right after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        #1;
        // reset values of the debug, baud and enable registers and the interrupt line
        rd(DBG_OFF, 16'h0000);
        rd(BAUD_OFF, 16'h0000);
        rd(ENCLR_OFF, 16'h0000);
        rd(ENSET_OFF, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // baud divisor, unmapped hole and a write lost while clock enable is low
        wr(BAUD_OFF, 16'ha5c3);
        chk(baud_value, 16'ha5c3);
        rd(BAUD_OFF, 16'ha5c3);
        wr(8'h0b, 16'hffff);
        rd(8'h0b, 16'h0000);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(BAUD_OFF, 16'h1234);
        @(posedge clock);
        clk_en <= 1'b1;
        rd(BAUD_OFF, 16'ha5c3);
        // set one source at a time, read back through the clear register
        exp_en = 4'h0;
        for (int i = 0; i < SRC_N; i++) begin
            exp_en[i] = 1'b1;
            wr(ENSET_OFF, 16'h0001 << i);
            rd(ENCLR_OFF, {12'h000, exp_en});
        end
        wr(ENSET_OFF, 16'h0000);
        wr(ENCLR_OFF, 16'h0000);
        rd(ENSET_OFF, 16'h000f);
        wr(ENCLR_OFF, 16'h0001 << XMIT_DONE_BIT);
        rd(ENSET_OFF, 16'h000d);
        exp_en = 4'hd;
        for (int i = 0; i < SRC_N; i++) begin
            exp_en[i] = 1'b0;
            wr(ENCLR_OFF, 16'h0001 << i);
            rd(ENSET_OFF, {12'h000, exp_en});
        end
        // holding-empty source: masked, enabled, masked again
        @(posedge clock);
        tx_holding_empty <= 1'b1;
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        wr(ENSET_OFF, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr(ENCLR_OFF, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        // receive-done follows unread data
        wr(ENSET_OFF, 16'h0004);
        @(posedge clock);
        rx_data_unread <= 1'b1;
        tick(2);
        chk({15'h0000, irq}, 16'h0001);
        rd(FLAG_OFF, 16'h0005);
        @(posedge clock);
        rx_data_unread <= 1'b0;
        tx_holding_empty <= 1'b0;
        tick(2);
        chk({15'h0000, irq}, 16'h0000);
        // transmit-done: pulse sets it, new transmit data clears it
        wr(ENSET_OFF, 16'h0002);
        @(posedge clock);
        tx_shift_done <= 1'b1;
        @(posedge clock);
        tx_shift_done <= 1'b0;
        tick(1);
        chk({15'h0000, irq}, 16'h0001);
        @(posedge clock);
        tx_data_written <= 1'b1;
        @(posedge clock);
        tx_data_written <= 1'b0;
        tick(1);
        chk({15'h0000, irq}, 16'h0000);
        // receive start: falling receive line with detection enabled
        wr(ENSET_OFF, 16'h0008);
        @(posedge clock);
        frame_start_detect_enable <= 1'b1;
        rx_line <= 1'b0;
        for (n = 0; n < 10 && irq !== 1'b1; n++) tick(1);
        chk({15'h0000, irq}, 16'h0001);
        rd(FLAG_OFF, 16'h0008);
        wr(FLAG_OFF, 16'h0008);
        chk({15'h0000, irq}, 16'h0000);
        // debug halt: generator keeps running unless the halt bit is set
        @(posedge clock);
        cpu_debug_halted <= 1'b1;
        tick(2);
        chk({15'h0000, baud_run}, 16'h0001);
        wr(DBG_OFF, 16'h00ff);
        tick(1);
        chk({15'h0000, baud_run}, 16'h0000);
        rd(DBG_OFF, 16'h0001);
        @(posedge clock);
        cpu_debug_halted <= 1'b0;
        tick(2);
        chk({15'h0000, baud_run}, 16'h0001);
        give_verdict();
    end
endmodule : tb_usart_irq_bank
